// ### verilog/lane_pattern_gen_check.sv
// lane loopback pattern generator, aligner and checker
`timescale 1ns/100ps
`include "lane_test_map.svh"

module lane_pattern_gen_check
    import lane_test_pkg::*;
#(
    parameter int SLIP_HOLD = `LT_SLIP_HOLD_WORDS,
    parameter int SLIP_SETTLE = `LT_SLIP_SETTLE_WORDS
) (
    // clock and synchronous reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // device level
    input wire logic i_device_init_done,
    // lane status and clocks
    input wire logic i_tx_regional_clock,
    input wire logic i_rx_regional_clock,
    input wire logic i_tx_path_ready,
    input wire logic i_rx_path_ready,
    input wire logic i_rx_word_valid,
    input wire logic i_rx_electrical_idle,
    input wire logic i_rx_block_lock,
    // lane data
    input wire lane_word_s i_rx_word,
    output lane_word_s o_tx_word,
    // lane control
    output logic o_lane_slip_request,
    output logic o_coding_layer_reset_n,
    output logic o_serdes_reset_n,
    // summary flags
    output logic o_aligned,
    output logic o_error
);

    // refuse counts the 8-bit slip counter cannot hold
    if (SLIP_HOLD < 1 || SLIP_HOLD > 255 ||
        SLIP_SETTLE < 1 || SLIP_SETTLE > 255) begin : g_bad_slip
        $error("slip counts must lie in 1..255");
    end

    localparam logic [7:0] HOLD_LAST = 8'(SLIP_HOLD - 1);
    localparam logic [7:0] SETTLE_LAST = 8'(SLIP_SETTLE - 1);

    // self-synchronising PRBS-31 step: x^31 + x^28 + 1, bit 0 first
    function automatic logic [63:0] prbs_adv(input logic [63:0] w);
        logic [127:0] s;
        s = {64'h0, w};
        for (int i = 64; i < 128; i++) begin
            s[i] = s[i-31] ^ s[i-28];
        end
        return s[127:64];
    endfunction

    // control register and host access
    logic [3:0] ctrl_r; // start, mode, prbs, lane release
    logic [31:0] words_r; // words checked
    logic [31:0] errs_r; // mismatching words
    lane_status_s status; // live status view

    // two-stage synchronisers for every lane and device input
    logic [7:0] flag_s1_r; // first stage, read only by stage two
    logic [7:0] flag_s2_r; // synchronised flags
    lane_word_s rxw_s1_r; // first stage of receive word
    lane_word_s rxw_s2_r; // synchronised receive word
    logic tx_clk_prev_r; // last seen transmit clock level
    logic rx_clk_prev_r; // last seen receive clock level

    // decoded synchronised inputs
    logic tx_clk_q, rx_clk_q, tx_rdy_q, rx_rdy_q;
    logic rx_val_q, rx_idle_q, lock_q, init_q;
    logic tx_fall, rx_fall;
    lane_mode_e mode;

    // run enables for generator and checker
    logic gen_run_r;
    logic chk_run_r;

    // aligner
    align_state_e al_state_r;
    logic [7:0] al_cnt_r;
    logic aligned_r;

    // generator
    logic [63:0] gen_cnt_r;
    logic [63:0] gen_prbs_r;

    // checker
    logic [63:0] last_r;
    logic seeded_r;
    logic err_r;
    logic chk_word;
    logic [63:0] expect_w;
    logic word_bad;

    // synchronise flags, clocks and data before any logic sees them
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            flag_s1_r <= 8'h00;
            flag_s2_r <= 8'h00;
            rxw_s1_r <= '0;
            rxw_s2_r <= '0;
        end else begin
            flag_s1_r <= {i_tx_regional_clock, i_rx_regional_clock,
                          i_tx_path_ready, i_rx_path_ready,
                          i_rx_word_valid, i_rx_electrical_idle,
                          i_rx_block_lock, i_device_init_done};
            flag_s2_r <= flag_s1_r;
            rxw_s1_r <= i_rx_word;
            rxw_s2_r <= rxw_s1_r;
        end
    end

    assign {tx_clk_q, rx_clk_q, tx_rdy_q, rx_rdy_q,
            rx_val_q, rx_idle_q, lock_q, init_q} = flag_s2_r;
    assign mode = lane_mode_e'(ctrl_r[`LT_CTRL_MODE]);

    // remember the lane clock levels to find their edges
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            tx_clk_prev_r <= 1'b0;
            rx_clk_prev_r <= 1'b0;
        end else begin
            tx_clk_prev_r <= tx_clk_q;
            rx_clk_prev_r <= rx_clk_q;
        end
    end

    // act on falling lane clock edges: mid-period, away from the
    // rising edge where the lane launches and takes its words
    assign tx_fall = tx_clk_prev_r & ~tx_clk_q;
    assign rx_fall = rx_clk_prev_r & ~rx_clk_q;

    // host register writes
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            ctrl_r <= `LT_CTRL_RST;
        end else if (i_wr && i_addr == `LT_ADDR_CTRL) begin
            ctrl_r <= i_wdata[3:0];
        end
    end

    // lane resets stay asserted from start-up until software
    // releases them; both reset inputs of the lane follow one bit
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_coding_layer_reset_n <= 1'b0;
            o_serdes_reset_n <= 1'b0;
        end else begin
            o_coding_layer_reset_n <= ctrl_r[`LT_CTRL_LANE_ON];
            o_serdes_reset_n <= ctrl_r[`LT_CTRL_LANE_ON];
        end
    end

    // generator and checker leave reset only once their lane side,
    // the device and the host start command all agree
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            gen_run_r <= 1'b0;
            chk_run_r <= 1'b0;
        end else begin
            gen_run_r <= ctrl_r[`LT_CTRL_START] & init_q & tx_rdy_q
                         & o_coding_layer_reset_n;
            chk_run_r <= ctrl_r[`LT_CTRL_START] & init_q & rx_rdy_q
                         & o_coding_layer_reset_n;
        end
    end

    // aligner: slip until a comma is framed, then hold alignment
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !chk_run_r || mode != MODE_BIT_SLIP) begin
            al_state_r <= AL_HUNT;
            al_cnt_r <= 8'h00;
        end else if (rx_fall && rx_val_q) begin
            case (al_state_r)
                AL_HUNT: begin
                    // compare the low 40 data bits of the word with the comma
                    if (rxw_s2_r.data[39:0] == `LT_COMMA_WORD) begin
                        al_state_r <= AL_ALIGNED;
                    end else begin
                        al_state_r <= AL_SLIP;
                    end
                    al_cnt_r <= 8'h00;
                end
                AL_SLIP: begin
                    // hold the slip request high for a few words
                    if (al_cnt_r == HOLD_LAST) begin
                        al_state_r <= AL_SETTLE;
                        al_cnt_r <= 8'h00;
                    end else begin
                        al_cnt_r <= al_cnt_r + 8'h01;
                    end
                end
                AL_SETTLE: begin
                    // low again so the next request is a new edge
                    if (al_cnt_r == SETTLE_LAST) begin
                        al_state_r <= AL_HUNT;
                        al_cnt_r <= 8'h00;
                    end else begin
                        al_cnt_r <= al_cnt_r + 8'h01;
                    end
                end
                AL_ALIGNED: begin
                    al_state_r <= AL_ALIGNED;
                end
                default: begin
                    al_state_r <= AL_HUNT;
                end
            endcase
        end
    end

    // slip pin and alignment flag, one flip-flop each
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_lane_slip_request <= 1'b0;
            aligned_r <= 1'b0;
        end else begin
            // each high phase gives the lane one rising edge
            o_lane_slip_request <= (al_state_r == AL_SLIP);
            if (mode == MODE_BIT_SLIP) begin
                aligned_r <= (al_state_r == AL_ALIGNED);
            end else begin
                aligned_r <= chk_run_r & lock_q & rx_rdy_q;
            end
        end
    end

    // generator: preamble until aligned or locked, then payload
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !gen_run_r) begin
            o_tx_word <= '0;
            gen_cnt_r <= 64'h0;
            gen_prbs_r <= `LT_PRBS_SEED;
        end else if (tx_fall) begin
            if (mode == MODE_BIT_SLIP) begin
                o_tx_word.hdr <= 2'h0;
                if (aligned_r) begin
                    // 40-bit counter in the low lanes
                    o_tx_word.data <= {24'h0, gen_cnt_r[39:0]};
                    gen_cnt_r <= {24'h0, gen_cnt_r[39:0] + 40'h1};
                end else begin
                    o_tx_word.data <= {24'h0, `LT_COMMA_WORD};
                end
            end else if (lock_q && rx_rdy_q) begin
                o_tx_word.hdr <= `LT_HDR_DATA;
                if (ctrl_r[`LT_CTRL_PRBS]) begin
                    o_tx_word.data <= gen_prbs_r;
                    gen_prbs_r <= prbs_adv(gen_prbs_r);
                end else begin
                    o_tx_word.data <= gen_cnt_r;
                    gen_cnt_r <= gen_cnt_r + 64'h1;
                end
            end else begin
                o_tx_word.hdr <= `LT_HDR_CTRL;
                o_tx_word.data <= `LT_SOS_BLOCK;
            end
        end
    end

    // which received words the checker looks at
    always_comb begin
        chk_word = 1'b0;
        if (rx_fall && rx_val_q && chk_run_r) begin
            if (mode == MODE_BIT_SLIP) begin
                // commas still in flight after alignment are skipped
                chk_word = aligned_r &&
                    rxw_s2_r.data[39:0] != `LT_COMMA_WORD;
            end else begin
                // control blocks carry no payload
                chk_word = rxw_s2_r.hdr != `LT_HDR_CTRL;
            end
        end
    end

    // next value predicted from the last received word
    always_comb begin
        expect_w = last_r + 64'h1;
        word_bad = 1'b0;
        if (mode == MODE_BIT_SLIP) begin
            expect_w = {24'h0, last_r[39:0] + 40'h1};
            word_bad = rxw_s2_r.data[39:0] != expect_w[39:0];
        end else begin
            if (ctrl_r[`LT_CTRL_PRBS]) begin
                expect_w = prbs_adv(last_r);
            end
            word_bad = rxw_s2_r.hdr != `LT_HDR_DATA ||
                       rxw_s2_r.data != expect_w;
        end
    end

    // checker: seed from the first word, then compare each word
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !chk_run_r) begin
            last_r <= 64'h0;
            seeded_r <= 1'b0;
            err_r <= 1'b0;
            words_r <= 32'h0;
            errs_r <= 32'h0;
        end else if (chk_word) begin
            last_r <= rxw_s2_r.data;
            seeded_r <= 1'b1;
            if (seeded_r) begin
                words_r <= words_r + 32'h1;
                if (word_bad) begin
                    err_r <= 1'b1;
                    errs_r <= errs_r + 32'h1;
                end
            end
        end
    end

    // summary outputs from flip-flops
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            o_aligned <= 1'b0;
            o_error <= 1'b0;
        end else begin
            o_aligned <= aligned_r;
            o_error <= err_r;
        end
    end

    // live status view; idle flag is only observed
    always_comb begin
        status = '0;
        status.aligned = aligned_r;
        status.gen_run = gen_run_r;
        status.chk_run = chk_run_r;
        status.error = err_r;
        status.tx_ready = tx_rdy_q;
        status.rx_ready = rx_rdy_q;
        status.block_lock = lock_q;
        status.rx_idle = rx_idle_q;
        status.init_done = init_q;
    end

    // read data stands in the cycle after the strobe only
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || !i_rd) begin
            o_rdata <= 32'h0;
        end else begin
            case (i_addr)
                `LT_ADDR_CTRL: o_rdata <= {28'h0, ctrl_r};
                `LT_ADDR_STATUS: o_rdata <= status;
                `LT_ADDR_WORDS: o_rdata <= words_r;
                `LT_ADDR_ERRS: o_rdata <= errs_r;
                default: o_rdata <= 32'h0;
            endcase
        end
    end

endmodule

// ### verilog/lane_test_map.svh
// constants of the lane pattern generator and checker
// What this block does
// - each slip rising edge moves boundary one bit
// - bit-slip mode sends 40-bit commas first
// - slip while misaligned, then flag alignment valid
// - after alignment send counter, start checking
// - bit-slip checker flags counter word mismatch
// - lane held in reset at start-up
// - 64b/66b counter payload is 64 bits wide
// - 64b/66b first sends start block, header 10
// - lock and ready: counter or PRBS with header 01
// - 64b/66b checker flags sequence mismatch
// - checker ignores words until valid indicated
// - 64b/66b payload counter or PRBS-31
// - generator and checker on system clock, at lane clock edges
// - bit-slip counter is 40 bits wide
// - aligner compares words with comma value
// - generator runs on tx ready, init, start
// - checker runs on rx ready, init, start
`ifndef LANE_TEST_MAP_SVH
`define LANE_TEST_MAP_SVH

// register byte offsets
`define LT_ADDR_CTRL 4'h0
`define LT_ADDR_STATUS 4'h4
`define LT_ADDR_WORDS 4'h8
`define LT_ADDR_ERRS 4'hC

// control register bit positions and reset value
`define LT_CTRL_START 0
`define LT_CTRL_MODE 1
`define LT_CTRL_PRBS 2
`define LT_CTRL_LANE_ON 3
`define LT_CTRL_RST 4'h0

// pattern values
`define LT_COMMA_WORD 40'hC14FAC14FA
`define LT_SOS_BLOCK 64'h7800000000000000
`define LT_HDR_CTRL 2'h2
`define LT_HDR_DATA 2'h1
// the step works on the top 31 bits of each word, so a seed with
// those bits all zero would leave the pattern stuck at zero
`define LT_PRBS_SEED 64'hFFFFFFFFFFFFFFFF

// slip timing counts, in received words
`define LT_SLIP_HOLD_WORDS 4
`define LT_SLIP_SETTLE_WORDS 8

`endif

// ### verilog/lane_test_pkg.sv
// types shared by the lane pattern generator and checker
package lane_test_pkg;

    // one lane word: sync header and 64-bit payload
    typedef struct packed {
        logic [1:0] hdr;
        logic [63:0] data;
    } lane_word_s;

    // pattern mode
    typedef enum logic {
        MODE_BIT_SLIP = 1'b0,
        MODE_64B66B = 1'b1
    } lane_mode_e;

    // aligner states, gray coded from hunt through slip to settle
    typedef enum logic [1:0] {
        AL_HUNT = 2'b00,
        AL_SLIP = 2'b01,
        AL_SETTLE = 2'b11,
        AL_ALIGNED = 2'b10
    } align_state_e;

    // status register layout
    typedef struct packed {
        logic [22:0] zero;
        logic init_done;
        logic rx_idle;
        logic block_lock;
        logic rx_ready;
        logic tx_ready;
        logic error;
        logic chk_run;
        logic gen_run;
        logic aligned;
    } lane_status_s;

endpackage

// ### sim/lane_test_asserts.sv
// port checks for the lane pattern block
`timescale 1ns/100ps
module lane_test_asserts
    import lane_test_pkg::*;
(
    // clock, reset and stimulus
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_wr,
    input wire logic i_device_init_done,
    // block outputs
    input wire lane_word_s o_tx_word,
    input wire logic o_lane_slip_request,
    input wire logic o_coding_layer_reset_n,
    input wire logic o_serdes_reset_n,
    input wire logic o_aligned,
    input wire logic o_error
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    logic [3:0] quiet_r; // cycles since the last write, saturating
    // a write may legally clear the error a few cycles later
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn || i_wr) begin
            quiet_r <= 4'h0;
        end else if (quiet_r != 4'hF) begin
            quiet_r <= quiet_r + 4'h1;
        end
    end
    reset_clears_a: assert property (disable iff (1'b0)
        !i_resetn |=> !o_error && !o_aligned && !o_serdes_reset_n
        && o_tx_word == '0) else $error("outputs not cleared by reset");
    resets_paired_a: assert property (
        o_coding_layer_reset_n == o_serdes_reset_n)
        else $error("lane resets differ");
    slip_hold_a: assert property (
        $rose(o_lane_slip_request) |-> o_lane_slip_request [*6])
        else $error("slip request too short");
    slip_settle_a: assert property (
        $fell(o_lane_slip_request) |-> !o_lane_slip_request [*8])
        else $error("slip request without settle gap");
    no_slip_aligned_a: assert property (
        o_aligned |-> !o_lane_slip_request)
        else $error("slip while aligned");
    high_bits_zero_a: assert property (
        o_tx_word.hdr == 2'h0 |-> o_tx_word.data[63:40] == 24'h0)
        else $error("bit-slip word wider than 40 bits");
    header_legal_a: assert property (
        o_tx_word.hdr != 2'h3) else $error("illegal sync header");
    gen_gated_a: assert property (
        o_tx_word != '0 |-> $past(i_device_init_done, 3))
        else $error("generator ran before init done");
    error_sticky_a: assert property (
        o_error && quiet_r == 4'hF |=> o_error)
        else $error("error flag dropped");
endmodule

// ### sim/lane_far_model.sv
// loopback lane model with bit slip, valid and block lock
`timescale 1ns/100ps
module lane_far_model
    import lane_test_pkg::*;
(
    // lane control and data from the block
    input wire logic i_coding_n,
    input wire logic i_serdes_n,
    input wire logic i_slip,
    input wire logic i_corrupt,
    input wire lane_word_s i_tx,
    // lane clock, status and data to the block
    output logic o_clk,
    output logic o_ready,
    output logic o_valid,
    output logic o_idle,
    output logic o_lock,
    output lane_word_s o_rx,
    output logic [5:0] o_off
);
    logic rst_n; // lane held while either reset is low
    lane_word_s w; // word in flight on the loop
    assign rst_n = i_coding_n & i_serdes_n;
    assign o_idle = !rst_n;
    // free running link clock, phase off the system clock
    initial begin
        o_clk = 1'b0;
        #37;
        forever #100 o_clk = ~o_clk;
    end
    // each slip rising edge moves the boundary one bit
    always @(posedge i_slip or negedge rst_n) begin
        if (!rst_n) begin
            o_off <= 6'd38;
        end else begin
            o_off <= (o_off == 6'd39) ? 6'd0 : o_off + 6'd1;
        end
    end
    // status and loopback data, one word per link clock
    always @(posedge o_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ready <= 1'b0;
            o_valid <= 1'b0;
            o_lock <= 1'b0;
            w <= '0;
            o_rx <= '0;
        end else begin
            o_ready <= 1'b1;
            // valid only once a sent word is on the loop, so idle
            // words ahead of the first one never pass as data
            o_valid <= o_ready && (o_valid || w != '0);
            w <= i_tx ^ {65'h0, i_corrupt};
            if (!(o_ready && (o_valid || w != '0))) begin
                o_rx <= ~o_rx;
            end else if (w.hdr == 2'h0) begin
                o_rx <= {26'h0, (w.data[39:0] >> o_off)
                    | (w.data[39:0] << (6'd40 - o_off))};
            end else begin
                o_rx <= w;
            end
            if (o_valid && w.hdr == 2'h2) begin
                o_lock <= 1'b1;
            end
        end
    end
endmodule

// ### sim/tb.sv
// self-checking bench for the lane pattern block
`timescale 1ns/100ps
`include "lane_test_map.svh"
module tb;
    import lane_test_pkg::*;
    logic clk = 1'b0; // system clock
    logic resetn = 1'b0; // active low reset
    logic [3:0] addr = 4'h0; // register address
    logic [31:0] wdata = 32'h0; // write data
    logic wr = 1'b0; // write strobe
    logic rd = 1'b0; // read strobe
    logic init = 1'b0; // device init done
    logic corrupt = 1'b0; // spoil one lane word
    logic [31:0] rdata, r; // read port and last read
    logic lclk, ready, valid, idle, lock, slip, pcs_n, pma_n, aligned, err;
    logic [5:0] off; // lane boundary offset
    lane_word_s txw, rxw, a; // lane words and a saved one
    int error_cnt = 0;
    int tests_run = 0;
    int i;
    always #12.5 clk = ~clk;
    lane_pattern_gen_check #(.SLIP_HOLD(1), .SLIP_SETTLE(2)) uut (
        .i_clk_sys(clk), .i_resetn(resetn), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_device_init_done(init), .i_tx_regional_clock(lclk),
        .i_rx_regional_clock(lclk), .i_tx_path_ready(ready),
        .i_rx_path_ready(ready), .i_rx_word_valid(valid),
        .i_rx_electrical_idle(idle), .i_rx_block_lock(lock),
        .i_rx_word(rxw), .o_tx_word(txw), .o_lane_slip_request(slip),
        .o_coding_layer_reset_n(pcs_n), .o_serdes_reset_n(pma_n),
        .o_aligned(aligned), .o_error(err));
    lane_far_model lane (
        .i_coding_n(pcs_n), .i_serdes_n(pma_n), .i_slip(slip),
        .i_corrupt(corrupt), .i_tx(txw), .o_clk(lclk), .o_ready(ready),
        .o_valid(valid), .o_idle(idle), .o_lock(lock), .o_rx(rxw),
        .o_off(off));
    // compare and count
    task chk(input string n, input logic [65:0] s, input logic [65:0] e);
        tests_run++;
        if (s !== e) begin
            error_cnt++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    // one-cycle register write
    task wr_reg(input logic [3:0] ad, input logic [31:0] d);
        addr <= ad;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read strobe, data taken at the edge after
    task rd_reg(input logic [3:0] ad);
        addr <= ad;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        r = rdata;
    endtask
    // wait for the tx word to move on
    task next_word;
        a = txw;
        for (i = 0; i < 40 && txw === a; i++) @(posedge clk);
    endtask
    // bounded wait for alignment
    task wait_aligned;
        for (i = 0; i < 4000 && aligned !== 1'b1; i++) @(posedge clk);
    endtask
    // spoil exactly one link word
    task bad_word;
        corrupt <= 1'b1;
        repeat (8) @(posedge clk);
        corrupt <= 1'b0;
        repeat (80) @(posedge clk);
    endtask
    // after reset: lane held, registers at reset value
    task t_reset;
        chk("lane held", {pcs_n, pma_n}, 2'b00);
        rd_reg(4'h0);
        chk("ctrl", r, 32'h0);
        wr_reg(4'h4, 32'hFF);
        rd_reg(4'h4);
        chk("status", r, 32'h80);
        rd_reg(4'h2);
        chk("unmapped", r, 32'h0);
    endtask
    // start without init done: nothing runs
    task t_gate;
        wr_reg(4'h0, 32'h9);
        repeat (80) @(posedge clk);
        chk("gen idle", txw, 66'h0);
        rd_reg(4'h4);
        chk("run bits", r[2:1], 2'b00);
    endtask
    // bit-slip hunt, then counter
    task t_slip;
        init <= 1'b1;
        for (i = 0; i < 400 && txw === 66'h0; i++) @(posedge clk);
        chk("comma", txw, {26'h0, `LT_COMMA_WORD});
        wait_aligned;
        chk("aligned", aligned, 1'b1);
        chk("boundary", off, 6'd0);
        next_word;
        next_word;
        chk("count", txw.data, a.data + 64'h1);
        repeat (200) @(posedge clk);
        chk("clean", err, 1'b0);
        rd_reg(4'h8);
        chk("checked", r != 32'h0, 1'b1);
    endtask
    // mismatch sets a sticky error, checker reset clears it
    task t_error;
        bad_word;
        chk("err set", err, 1'b1);
        repeat (200) @(posedge clk);
        chk("err held", err, 1'b1);
        rd_reg(4'hC);
        chk("errs", r != 32'h0, 1'b1);
        wr_reg(4'h0, 32'h0);
        repeat (40) @(posedge clk);
        chk("err clear", err, 1'b0);
    endtask
    // 64b/66b start block, then counter and a fault
    task t_fast;
        wr_reg(4'h0, 32'hB);
        for (i = 0; i < 400 && txw === 66'h0; i++) @(posedge clk);
        chk("sos", txw, {`LT_HDR_CTRL, `LT_SOS_BLOCK});
        wait_aligned;
        next_word;
        next_word;
        chk("hdr", txw.hdr, `LT_HDR_DATA);
        chk("count64", txw.data, a.data + 64'h1);
        repeat (200) @(posedge clk);
        chk("clean64", err, 1'b0);
        bad_word;
        chk("err64", err, 1'b1);
        wr_reg(4'h0, 32'h0);
        repeat (40) @(posedge clk);
    endtask
    // 64b/66b with the PRBS payload
    task t_prbs;
        wr_reg(4'h0, 32'hF);
        wait_aligned;
        next_word;
        next_word;
        chk("prbs hdr", txw.hdr, `LT_HDR_DATA);
        chk("not count", txw.data !== a.data + 64'h1, 1'b1);
        chk("prbs live", txw.data != 64'h0 && txw.data !== a.data, 1'b1);
        repeat (400) @(posedge clk);
        chk("prbs clean", err, 1'b0);
    endtask
    // verdict and end of run
    task close_out;
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #1000000;
        error_cnt++;
        close_out;
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        t_reset;
        t_gate;
        t_slip;
        t_error;
        t_fast;
        t_prbs;
        close_out;
    end
endmodule
bind lane_pattern_gen_check lane_test_asserts chk_i (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_wr(i_wr),
    .i_device_init_done(i_device_init_done), .o_tx_word(o_tx_word),
    .o_lane_slip_request(o_lane_slip_request),
    .o_coding_layer_reset_n(o_coding_layer_reset_n),
    .o_serdes_reset_n(o_serdes_reset_n), .o_aligned(o_aligned),
    .o_error(o_error));
